// *** core/pgp_pkg.sv ***
// Package with register map, reset values and carrier types of the port block.
package pgp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int NUM_MATCH = 2;
    localparam int PORT_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_OFS [NUM_PORTS] = '{8'h80, 8'h90, 8'ha0};
    localparam logic [7:0] DRIVE_OFS [NUM_PORTS] = '{8'ha4, 8'ha5, 8'ha6};
    localparam logic [7:0] ANALOG_OFS [NUM_PORTS] = '{8'hf1, 8'hf2, 8'hf3};
    localparam logic [7:0] SKIP_OFS [NUM_PORTS] = '{8'hd4, 8'hd5, 8'hd6};
    localparam logic [7:0] CMP_VALUE_OFS [NUM_MATCH] = '{8'he1, 8'he2};
    localparam logic [7:0] CMP_MASK_OFS [NUM_MATCH] = '{8'he3, 8'he4};
    localparam logic [7:0] IRQ_STATUS_OFS = 8'he8;
    localparam logic [7:0] IRQ_MASK_OFS = 8'he9;

    // ------------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'hff;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [7:0] ANALOG_RST = 8'hff;
    localparam logic [7:0] SKIP_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'h00;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int IRQ_MATCH0_BIT = 0;
    localparam int IRQ_MATCH1_BIT = 1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic rmw;
    } pgp_bus_req_t;

    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] digital;
        logic [7:0] pushpull;
    } pgp_port_cfg_t;

endpackage

// *** core/pgp_pin_cell.sv ***
// One eight-pin port: drive, pull-up and receiver control plus the pin read level.
`timescale 1ns/1ps
module pgp_pin_cell
    import pgp_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Configuration and pins
    input wire pgp_port_cfg_t i_cfg,
    input wire logic [7:0] i_pin,
    // Read level and pad controls
    output logic [7:0] o_level,
    output logic [7:0] o_pin_out,
    output logic [7:0] o_pin_oe_n,
    output logic [7:0] o_pullup_en,
    output logic [7:0] o_rx_en
);

    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe_n;
    logic [7:0] next_pullup_en;
    logic [7:0] next_rx_en;

    // Analog pins read zero because their receiver is off.
    assign o_level = i_pin & i_cfg.digital;

    always_comb begin
        next_pin_out = i_cfg.latch;
        // Drive when digital and either push-pull or holding a low.
        next_pin_oe_n = ~(i_cfg.digital & (i_cfg.pushpull | ~i_cfg.latch));
        next_pullup_en = i_cfg.digital;
        next_rx_en = i_cfg.digital;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_pin_out <= 8'hff;
            o_pin_oe_n <= 8'hff;
            o_pullup_en <= 8'h00;
            o_rx_en <= 8'h00;
        end else if (i_ce) begin
            o_pin_out <= next_pin_out;
            o_pin_oe_n <= next_pin_oe_n;
            o_pullup_en <= next_pullup_en;
            o_rx_en <= next_rx_en;
        end
    end

endmodule // pgp_pin_cell

// *** core/pgp_match_cmp.sv ***
// Masked compare of a port's read levels against a software value.
`timescale 1ns/1ps
module pgp_match_cmp
    import pgp_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Compare inputs
    input wire logic [7:0] i_level,
    input wire logic [7:0] i_value,
    input wire logic [7:0] i_mask,
    // Mismatch level
    output logic o_mismatch
);

    logic next_mismatch;

    always_comb begin
        next_mismatch = (i_level & i_mask) != (i_value & i_mask);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mismatch <= 1'b0;
        end else if (i_ce) begin
            o_mismatch <= next_mismatch;
        end
    end

endmodule // pgp_match_cmp

// *** core/pgp_port_io.sv ***
// Top of the three-port general-purpose pin block with its register file.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module pgp_port_io
    import pgp_pkg::*;
(
    // Clock, reset and clock enable
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register port
    input wire pgp_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    // Pins
    input wire logic [NUM_PORTS-1:0][7:0] i_pin,
    output logic [NUM_PORTS-1:0][7:0] o_pin_out,
    output logic [NUM_PORTS-1:0][7:0] o_pin_oe_n,
    output logic [NUM_PORTS-1:0][7:0] o_pullup_en,
    output logic [NUM_PORTS-1:0][7:0] o_rx_en,
    // Router and event outputs
    output logic [NUM_PORTS-1:0][7:0] o_skip,
    output logic [NUM_MATCH-1:0] o_match_event,
    output logic o_irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] latch [NUM_PORTS];
    logic [7:0] analog_sel [NUM_PORTS];
    logic [7:0] drive_sel [NUM_PORTS];
    logic [7:0] cmp_value [NUM_MATCH];
    logic [7:0] cmp_mask [NUM_MATCH];
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    logic [7:0] next_latch [NUM_PORTS];
    logic [7:0] next_analog_sel [NUM_PORTS];
    logic [7:0] next_drive_sel [NUM_PORTS];
    logic [7:0] next_skip [NUM_PORTS];
    logic [7:0] next_cmp_value [NUM_MATCH];
    logic [7:0] next_cmp_mask [NUM_MATCH];
    logic [1:0] next_irq_status;
    logic [1:0] next_irq_mask;
    logic [7:0] next_rdata;
    logic next_irq;

    logic [7:0] level [NUM_PORTS];
    logic [1:0] irq_clear;

    // Decoding of one strobe against one offset, used by every register.
    function automatic logic hit(input pgp_bus_req_t req, input logic [7:0] ofs, input logic strobe);
        hit = strobe && (req.addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Pin cells and match comparators
    // ------------------------------------------------------------------
    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            pgp_port_cfg_t cfg;
            assign cfg.latch = latch[p];
            assign cfg.digital = analog_sel[p];
            assign cfg.pushpull = drive_sel[p];
            pgp_pin_cell u_cell (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_cfg(cfg),
                .i_pin(i_pin[p]),
                .o_level(level[p]),
                .o_pin_out(o_pin_out[p]),
                .o_pin_oe_n(o_pin_oe_n[p]),
                .o_pullup_en(o_pullup_en[p]),
                .o_rx_en(o_rx_en[p])
            );
        end
        for (genvar m = 0; m < NUM_MATCH; m++) begin : g_match
            pgp_match_cmp u_cmp (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_ce(i_ce),
                .i_level(level[m]),
                .i_value(cmp_value[m]),
                .i_mask(cmp_mask[m]),
                .o_mismatch(o_match_event[m])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register writes and reads
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = RDATA_UNMAPPED;
        irq_clear = 2'h0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_latch[p] = latch[p];
            next_analog_sel[p] = analog_sel[p];
            next_drive_sel[p] = drive_sel[p];
            next_skip[p] = o_skip[p];
            if (hit(i_bus, DATA_OFS[p], i_bus.wr)) begin
                next_latch[p] = i_bus.wdata;
            end
            if (hit(i_bus, ANALOG_OFS[p], i_bus.wr)) begin
                next_analog_sel[p] = i_bus.wdata;
            end
            if (hit(i_bus, DRIVE_OFS[p], i_bus.wr)) begin
                next_drive_sel[p] = i_bus.wdata;
            end
            if (hit(i_bus, SKIP_OFS[p], i_bus.wr)) begin
                next_skip[p] = i_bus.wdata;
            end
            // Read-modify-write sequences must see the latch, or a pin held low
            // by the board would be written back as a low.
            if (hit(i_bus, DATA_OFS[p], i_bus.rd)) begin
                next_rdata = i_bus.rmw ? latch[p] : level[p];
            end
            if (hit(i_bus, ANALOG_OFS[p], i_bus.rd)) begin
                next_rdata = analog_sel[p];
            end
            if (hit(i_bus, DRIVE_OFS[p], i_bus.rd)) begin
                next_rdata = drive_sel[p];
            end
            if (hit(i_bus, SKIP_OFS[p], i_bus.rd)) begin
                next_rdata = o_skip[p];
            end
        end
        for (int m = 0; m < NUM_MATCH; m++) begin
            next_cmp_value[m] = cmp_value[m];
            next_cmp_mask[m] = cmp_mask[m];
            if (hit(i_bus, CMP_VALUE_OFS[m], i_bus.wr)) begin
                next_cmp_value[m] = i_bus.wdata;
            end
            if (hit(i_bus, CMP_MASK_OFS[m], i_bus.wr)) begin
                next_cmp_mask[m] = i_bus.wdata;
            end
            if (hit(i_bus, CMP_VALUE_OFS[m], i_bus.rd)) begin
                next_rdata = cmp_value[m];
            end
            if (hit(i_bus, CMP_MASK_OFS[m], i_bus.rd)) begin
                next_rdata = cmp_mask[m];
            end
        end
        next_irq_mask = irq_mask;
        if (hit(i_bus, IRQ_MASK_OFS, i_bus.wr)) begin
            next_irq_mask = i_bus.wdata[1:0];
        end
        if (hit(i_bus, IRQ_STATUS_OFS, i_bus.wr)) begin
            irq_clear = i_bus.wdata[1:0];
        end
        if (hit(i_bus, IRQ_MASK_OFS, i_bus.rd)) begin
            next_rdata = {6'h00, irq_mask};
        end
        if (hit(i_bus, IRQ_STATUS_OFS, i_bus.rd)) begin
            next_rdata = {6'h00, irq_status};
        end
        // A mismatch present in the clearing cycle sets the bit again.
        next_irq_status = (irq_status & ~irq_clear) | o_match_event;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch[p] <= DATA_RST;
                analog_sel[p] <= ANALOG_RST;
                drive_sel[p] <= DRIVE_RST;
                o_skip[p] <= SKIP_RST;
            end
            for (int m = 0; m < NUM_MATCH; m++) begin
                cmp_value[m] <= CMP_RST;
                cmp_mask[m] <= CMP_RST;
            end
            irq_status <= IRQ_RST;
            irq_mask <= IRQ_RST;
            o_rdata <= RDATA_UNMAPPED;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                latch[p] <= next_latch[p];
                analog_sel[p] <= next_analog_sel[p];
                drive_sel[p] <= next_drive_sel[p];
                o_skip[p] <= next_skip[p];
            end
            for (int m = 0; m < NUM_MATCH; m++) begin
                cmp_value[m] <= next_cmp_value[m];
                cmp_mask[m] <= next_cmp_mask[m];
            end
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            o_rdata <= next_rdata;
            o_irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_latch_write: assert property (
        i_ce && hit(i_bus, DATA_OFS[0], i_bus.wr)
        |=> latch[0] == $past(i_bus.wdata))
        else $error("Port data write was not latched.");

    a_third_latch: assert property (
        i_ce && hit(i_bus, DATA_OFS[2], i_bus.wr)
        |=> latch[2] == $past(i_bus.wdata))
        else $error("Third port data write was not latched.");

    a_pin_follows: assert property (
        i_ce
        |=> o_pin_out[2] == $past(latch[2]))
        else $error("Pin output value differs from the latch.");

    a_opendrain_float: assert property (
        i_ce
        |=> (~o_pin_oe_n[0] & $past(latch[0]) & ~$past(drive_sel[0])) == 8'h00)
        else $error("Open-drain pin holding one is driven.");

    a_analog_read: assert property (
        i_ce && hit(i_bus, DATA_OFS[1], i_bus.rd) && !i_bus.rmw
        |=> (o_rdata & ~$past(analog_sel[1])) == 8'h00)
        else $error("Analog pin read back nonzero.");

    a_digital_read: assert property (
        i_ce && hit(i_bus, DATA_OFS[1], i_bus.rd) && !i_bus.rmw
        |=> o_rdata == ($past(i_pin[1]) & $past(analog_sel[1])))
        else $error("Digital pin read differs from pin level.");

    a_third_read: assert property (
        i_ce && hit(i_bus, DATA_OFS[2], i_bus.rd) && !i_bus.rmw
        |=> o_rdata == ($past(i_pin[2]) & $past(analog_sel[2])))
        else $error("Third port read is wrong.");

    a_analog_off: assert property (
        i_ce
        |=> ((o_pullup_en[0] | o_rx_en[0] | ~o_pin_oe_n[0]) & ~$past(analog_sel[0])) == 8'h00)
        else $error("Analog pin has pull-up, driver or receiver on.");

    a_pullup_rx: assert property (
        i_ce
        |=> o_pullup_en[1] == $past(analog_sel[1]) && o_rx_en[1] == $past(analog_sel[1]))
        else $error("Pull-up or receiver does not follow the input mode.");

    a_drive_ignored: assert property (
        i_ce && !analog_sel[0][7] && drive_sel[0][7]
        |=> o_pin_oe_n[0][7])
        else $error("Drive select acted on an analog pin.");

    a_pushpull_high: assert property (
        i_ce && analog_sel[2][2] && drive_sel[2][2] && latch[2][2]
        |=> !o_pin_oe_n[2][2] && o_pin_out[2][2])
        else $error("Push-pull pin holding one not driven high.");

    a_opendrain_low: assert property (
        i_ce && analog_sel[0][7] && !drive_sel[0][7] && !latch[0][7]
        |=> !o_pin_oe_n[0][7] && !o_pin_out[0][7])
        else $error("Open-drain pin holding zero not driven low.");

    a_match_detect: assert property (
        i_ce && ((level[0] & cmp_mask[0]) != (cmp_value[0] & cmp_mask[0]))
        |=> o_match_event[IRQ_MATCH0_BIT])
        else $error("Masked mismatch did not raise the match event.");

    a_match_port1: assert property (
        i_ce && ((level[1] & cmp_mask[1]) != (cmp_value[1] & cmp_mask[1]))
        |=> o_match_event[IRQ_MATCH1_BIT])
        else $error("Second port mismatch did not raise the match event.");

    a_match_quiet: assert property (
        i_ce && ((level[0] & cmp_mask[0]) == (cmp_value[0] & cmp_mask[0]))
        |=> !o_match_event[IRQ_MATCH0_BIT])
        else $error("Match event raised while the masked levels agree.");

    a_match_sets: assert property (
        i_ce && o_match_event[IRQ_MATCH1_BIT]
        |=> irq_status[IRQ_MATCH1_BIT])
        else $error("Match event did not set its status bit.");

    a_status_sticky: assert property (
        i_ce && irq_status[IRQ_MATCH0_BIT] && !(hit(i_bus, IRQ_STATUS_OFS, i_bus.wr) && i_bus.wdata[IRQ_MATCH0_BIT])
        |=> irq_status[IRQ_MATCH0_BIT])
        else $error("Status bit dropped without a clearing write.");

    a_status_clear: assert property (
        i_ce && hit(i_bus, IRQ_STATUS_OFS, i_bus.wr) && i_bus.wdata[IRQ_MATCH0_BIT] && !o_match_event[IRQ_MATCH0_BIT]
        |=> !irq_status[IRQ_MATCH0_BIT])
        else $error("Writing one did not clear the status bit.");

    a_rmw_latch: assert property (
        i_ce && hit(i_bus, DATA_OFS[1], i_bus.rd) && i_bus.rmw
        |=> o_rdata == $past(latch[1]))
        else $error("Read-modify-write read did not return the latch.");

    a_rmw_third: assert property (
        i_ce && hit(i_bus, DATA_OFS[2], i_bus.rd) && i_bus.rmw
        |=> o_rdata == $past(latch[2]))
        else $error("Third port read-modify-write read did not return the latch.");

    a_skip_write: assert property (
        i_ce && hit(i_bus, SKIP_OFS[1], i_bus.wr)
        |=> o_skip[1] == $past(i_bus.wdata))
        else $error("Skip register write lost.");

    a_irq_level: assert property (
        i_ce
        |=> o_irq == |(irq_status & irq_mask))
        else $error("Interrupt output disagrees with status and mask.");

    a_unmapped_read: assert property (
        i_ce && hit(i_bus, 8'h00, i_bus.rd)
        |=> o_rdata == RDATA_UNMAPPED)
        else $error("Unmapped address did not read the idle value.");

    a_ce_freeze: assert property (
        !i_ce
        |=> $stable(latch[0]) && $stable(o_rdata) && $stable(o_irq) && $stable(o_pin_out))
        else $error("State moved while the clock enable was low.");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_match_irq: cover property (o_match_event[0] ##1 irq_status[0] ##1 o_irq);
    c_rmw_read: cover property (i_ce && hit(i_bus, DATA_OFS[0], i_bus.rd) && i_bus.rmw);
    c_clear_vs_set: cover property (i_ce && hit(i_bus, IRQ_STATUS_OFS, i_bus.wr) && o_match_event[0]);
    c_freeze_write: cover property (!i_ce && hit(i_bus, DATA_OFS[0], i_bus.wr));
    c_port1_match: cover property (o_match_event[1] ##1 irq_status[1]);

endmodule // pgp_port_io

// *** test/pgp_board_model.sv ***
// Board-side model of the port pins: resolves each pin level from all drivers.
`timescale 1ns/1ps
module pgp_board_model
    import pgp_pkg::*;
(
    // Clock
    input wire logic i_mclk,
    // Board drivers
    input wire logic [NUM_PORTS-1:0][7:0] i_ext_val,
    input wire logic [NUM_PORTS-1:0][7:0] i_ext_en,
    // Pad controls from the port block
    input wire logic [NUM_PORTS-1:0][7:0] i_pin_out,
    input wire logic [NUM_PORTS-1:0][7:0] i_pin_oe_n,
    input wire logic [NUM_PORTS-1:0][7:0] i_pullup_en,
    // Resolved pin levels
    output logic [NUM_PORTS-1:0][7:0] o_level
);
    // An undriven pin without pull-up toggles every cycle, so a stale value never passes for a read.
    logic flip = 1'b0;

    always_ff @(posedge i_mclk) begin
        flip <= ~flip;
    end

    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!i_pin_oe_n[p][b]) begin
                    o_level[p][b] = i_pin_out[p][b];
                end else if (i_ext_en[p][b]) begin
                    o_level[p][b] = i_ext_val[p][b];
                end else if (i_pullup_en[p][b]) begin
                    o_level[p][b] = 1'b1;
                end else begin
                    o_level[p][b] = flip;
                end
            end
        end
    end
endmodule // pgp_board_model

// *** test/port_pin_config_and_data_tb_top.sv ***
// Register-level testbench of the three-port pin block.
`timescale 1ns/1ps
module port_pin_config_and_data_tb_top;
    import pgp_pkg::*;

    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    pgp_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic [NUM_PORTS-1:0][7:0] pins, pout, oe_n, pull, rx, skip;
    logic [NUM_PORTS-1:0][7:0] ext_val = '0;
    logic [NUM_PORTS-1:0][7:0] ext_en = '0;
    logic [NUM_MATCH-1:0] mev;
    logic irq;
    int err_count = 0;
    int checks_done = 0;

    pgp_port_io DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_bus(bus), .o_rdata(rdata),
        .i_pin(pins), .o_pin_out(pout), .o_pin_oe_n(oe_n), .o_pullup_en(pull), .o_rx_en(rx),
        .o_skip(skip), .o_match_event(mev), .o_irq(irq));

    pgp_board_model board (.i_mclk(i_mclk), .i_ext_val(ext_val), .i_ext_en(ext_en), .i_pin_out(pout),
        .i_pin_oe_n(oe_n), .i_pullup_en(pull), .o_level(pins));

    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    // ------------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge i_mclk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic rmw, input logic [7:0] exp, input string what);
        @(posedge i_mclk);
        bus.addr <= a;
        bus.rmw <= rmw;
        bus.rd <= 1'b1;
        @(posedge i_mclk);
        bus.rd <= 1'b0;
        bus.rmw <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask

    // Pads follow a write two edges later and events two more; five edges cover both.
    task automatic settle();
        repeat (5) @(posedge i_mclk);
        #1;
    endtask

    function automatic logic [7:0] exp_oe_n(input logic [7:0] dig, input logic [7:0] pp, input logic [7:0] lat);
        return ~(dig & (pp | ~lat));
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #(100 * 100000);
        err_count++;
        end_of_test();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        settle();
        for (int p = 0; p < NUM_PORTS; p++) begin
            rd(DRIVE_OFS[p], 1'b0, DRIVE_RST, "drive select reset");
            rd(ANALOG_OFS[p], 1'b0, ANALOG_RST, "analog select reset");
            rd(SKIP_OFS[p], 1'b0, SKIP_RST, "skip reset");
            rd(DATA_OFS[p], 1'b0, 8'hff, "pulled-up pin read");
        end
        for (int m = 0; m < NUM_MATCH; m++) begin
            rd(CMP_VALUE_OFS[m], 1'b0, CMP_RST, "compare value reset");
            rd(CMP_MASK_OFS[m], 1'b0, CMP_RST, "compare mask reset");
        end
        rd(IRQ_MASK_OFS, 1'b0, 8'h00, "irq mask reset");
        rd(8'h00, 1'b0, RDATA_UNMAPPED, "unmapped read");
        $display("test reset_values done");

        wr(8'ha4, 8'h0f);
        wr(8'h80, 8'h5a);
        settle();
        check("port0 pin out", 8'h5a, pout[0]);
        check("port0 oe_n", exp_oe_n(8'hff, 8'h0f, 8'h5a), oe_n[0]);
        rd(8'h80, 1'b0, 8'h5a, "port0 pin read");
        wr(8'hf1, 8'h0f);
        wr(8'ha4, 8'hff);
        wr(8'h80, 8'h00);
        settle();
        check("port0 oe_n analog", exp_oe_n(8'h0f, 8'hff, 8'h00), oe_n[0]);
        check("port0 pull-up analog", 8'h0f, pull[0]);
        check("port0 receiver analog", 8'h0f, rx[0]);
        $display("test port0_drive done");

        ext_en[1] <= 8'hff;
        ext_val[1] <= 8'h3c;
        settle();
        rd(8'h90, 1'b0, 8'h3c, "port1 digital read");
        rd(8'h90, 1'b1, 8'hff, "port1 latch read");
        wr(8'hf2, 8'hf0);
        settle();
        rd(8'h90, 1'b0, 8'h30, "port1 analog read");
        check("port1 receiver", 8'hf0, rx[1]);
        wr(8'hd5, 8'ha5);
        settle();
        check("port1 skip", 8'ha5, skip[1]);
        $display("test port1_read done");

        wr(8'ha6, 8'hff);
        wr(8'ha0, 8'h96);
        settle();
        check("port2 oe_n", 8'h00, oe_n[2]);
        rd(8'ha0, 1'b0, 8'h96, "port2 pin read");
        wr(8'hf3, 8'h0f);
        settle();
        rd(8'ha0, 1'b0, 8'h06, "port2 analog read");
        rd(8'ha0, 1'b1, 8'h96, "port2 latch read");
        $display("test port2 done");

        wr(8'hf1, 8'hff);
        wr(8'he3, 8'h01);
        wr(8'he8, 8'h03);
        wr(8'he9, 8'h01);
        settle();
        check("irq idle", 8'h00, {7'h00, irq});
        wr(8'h80, 8'h01);
        settle();
        check("port0 match event", 8'h01, {7'h00, mev[0]});
        check("irq raised", 8'h01, {7'h00, irq});
        rd(IRQ_STATUS_OFS, 1'b0, 8'h01, "irq status port0");
        wr(8'he9, 8'h00);
        settle();
        check("irq masked", 8'h00, {7'h00, irq});
        wr(8'h80, 8'h00);
        settle();
        wr(8'he8, 8'h01);
        settle();
        check("port0 match cleared", 8'h00, {7'h00, mev[0]});
        rd(IRQ_STATUS_OFS, 1'b0, 8'h00, "irq status cleared");
        wr(8'he2, 8'h30);
        wr(8'he4, 8'h30);
        settle();
        check("port1 no match event", 8'h00, {7'h00, mev[1]});
        rd(IRQ_STATUS_OFS, 1'b0, 8'h00, "irq status idle");
        ext_val[1] <= 8'h0c;
        wr(8'he9, 8'h02);
        settle();
        check("port1 match event", 8'h01, {7'h00, mev[1]});
        check("irq port1", 8'h01, {7'h00, irq});
        rd(IRQ_STATUS_OFS, 1'b0, 8'h02, "irq status port1");
        $display("test match done");

        @(posedge i_mclk);
        i_ce <= 1'b0;
        wr(8'h80, 8'hff);
        @(posedge i_mclk);
        i_ce <= 1'b1;
        rd(8'h80, 1'b1, 8'h00, "latch frozen by clock enable");
        check("irq after freeze", 8'h01, {7'h00, irq});
        $display("test clock_enable done");
        end_of_test();
    end
endmodule // port_pin_config_and_data_tb_top
